// ===== hw/autoneg_next_page_regs.sv
// Purpose: Next-page transmit and partner receive registers
// Assumes: APB slave, PHY clock, partner page strobes
// Notes:   Zero-wait-state APB, unmapped reads zero
//
// Summary of operation
// RULE1: The transmit register holds the full 16-bit next page word sent.
// RULE2: The transmit register resets to 0x2001, a null message page.
// RULE3: Bit 15 of the transmit word announces further pages when one.
// RULE4: Bit 14 of the transmit word is reserved, read-only and reads zero.
// RULE5: Bit 13 marks a formatted message page when one, unformatted when zero.
// RULE6: Bit 12 is the writable comply indication of the transmit word.
// RULE7: Bit 11 is a read-only toggle driven by the device.
// RULE8: Bits 10:0 are the writable code field sent unchanged.
// RULE9: The receive register captures the partner page and is read-only.
// RULE10: Bit 15 of the received word shows whether partner pages follow.
// RULE11: Bit 14 of the received word shows successful reception.
// RULE12: A page-received flag latches in the status register and clears on read.
// RULE13: The toggle inverts on each sent page, seeded from the base page.
// RULE14: The receive register updates only with a complete accepted page.
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs
   import np_regs_pkg::*;
(
   input  wire logic                      i_clk,
   input  wire logic                      i_rstn,
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [np_regs_pkg::ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]               i_pwdata,
   input  wire logic [3:0]                i_pstrb,
   input  wire logic                      i_page_sent,
   input  wire logic                      i_base_sent,
   input  wire logic                      i_base_alt,
   input  wire logic                      i_rx_valid,
   input  wire logic [15:0]               i_rx_word,
   output logic [31:0]                    o_prdata,
   output logic                           o_pready,
   output logic                           o_pslverr,
   output logic [15:0]                    o_tx_word,
   output logic                           o_np_enable
);
   import np_regs_pkg::*;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   page_bus_if sent_bus ();
   page_bus_if rx_bus ();
   logic        alt_bit;
   logic [15:0] rx_word;
   logic        rx_new;

   assign sent_bus.valid = i_page_sent;
   assign sent_bus.word  = o_tx_word;
   assign rx_bus.valid   = i_rx_valid;
   assign rx_bus.word    = i_rx_word;

   np_toggle_gen u_toggle (
      .i_clk             (i_clk),
      .i_rstn            (i_rstn),
      .i_base_sent       (i_base_sent),
      .i_base_alt        (i_base_alt),
      .sent              (sent_bus),
      .o_alternating_bit (alt_bit)
   );

   np_rx_capture u_rx (
      .i_clk      (i_clk),
      .i_rstn     (i_rstn),
      .rx         (rx_bus),
      .o_word     (rx_word),
      .o_new_page (rx_new)
   );

   // ---------------------------------------------
   // Register state
   // ---------------------------------------------
   logic [15:0] tx_q;
   logic [15:0] tx_d;
   logic        pr_q;
   logic        pr_d;
   logic        en_q;
   logic        en_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        ready_q;
   logic        ready_d;
   logic        err_q;
   logic        err_d;
   logic [15:0] tx_out_q;
   logic [15:0] tx_out_d;
   logic [15:0] tx_view;
   logic [15:0] ext_view;
   logic [15:0] wmask;
   logic        setup;
   logic        wr;
   logic        rd;
   logic        hit;

   // Bus acts in setup; pready high next cycle, so the
   // access phase always ends after one wait-free cycle.
   assign setup = i_psel && !i_penable;
   assign wr    = setup && i_pwrite;
   assign rd    = setup && !i_pwrite;
   assign wmask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

   always_comb begin
      tx_view = tx_q;
      tx_view[BIT_RSVD_ACK]    = 1'b0;    // RULE4
      tx_view[BIT_ALTERNATING] = alt_bit; // RULE7
      ext_view = EXT_CONST;
      ext_view[BIT_PAGE_RECEIVED] = pr_q;
      hit = (i_paddr == ADDR_NP_TRANSMIT) || (i_paddr == ADDR_NP_RECEIVED)
         || (i_paddr == ADDR_EXT_STATUS) || (i_paddr == ADDR_NP_CONTROL);
   end

   always_comb begin
      tx_d     = tx_q;
      pr_d     = pr_q;
      en_d     = en_q;
      rdata_d  = 32'h0000_0000;
      ready_d  = setup;
      err_d    = setup && !hit;
      tx_out_d = tx_view; // RULE1 RULE8
      if (wr && i_paddr == ADDR_NP_TRANSMIT) begin
         // Toggle and reserved bits are not storable
         tx_d = (tx_q & ~(wmask & TX_WRITE_MASK))
              | (i_pwdata[15:0] & wmask & TX_WRITE_MASK); // RULE3 RULE5 RULE6 RULE8
      end
      if (wr && i_paddr == ADDR_NP_CONTROL && i_pstrb[0]) begin
         en_d = i_pwdata[0];
      end
      if (rd) begin
         case (i_paddr)
            ADDR_NP_TRANSMIT: rdata_d = {16'h0000, tx_view};
            ADDR_NP_RECEIVED: rdata_d = {16'h0000, rx_word}; // RULE9 RULE10 RULE11
            ADDR_EXT_STATUS: begin
               rdata_d = {16'h0000, ext_view};
               pr_d    = 1'b0; // RULE12
            end
            ADDR_NP_CONTROL:  rdata_d = {31'h0000_0000, en_q};
            default:          rdata_d = 32'h0000_0000;
         endcase
      end
      // New page wins over a clearing read
      if (rx_new) begin
         pr_d = 1'b1; // RULE12
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tx_q     <= NP_RESET; // RULE2
         pr_q     <= 1'b0;
         en_q     <= NP_CONTROL_RESET[0];
         rdata_q  <= 32'h0000_0000;
         ready_q  <= 1'b0;
         err_q    <= 1'b0;
         tx_out_q <= NP_RESET;
      end else begin
         tx_q     <= tx_d;
         pr_q     <= pr_d;
         en_q     <= en_d;
         rdata_q  <= rdata_d;
         ready_q  <= ready_d;
         err_q    <= err_d;
         tx_out_q <= tx_out_d;
      end
   end

   assign o_prdata    = rdata_q;
   assign o_pready    = ready_q;
   assign o_pslverr   = err_q;
   assign o_tx_word   = tx_out_q;
   assign o_np_enable = en_q;
endmodule
`default_nettype wire

// ===== hw/np_regs_pkg.sv
// Purpose: Constants for the next-page register bank
// Assumes: 32-bit APB, one register per aligned word
// Notes:   Printed offsets are register indices
package np_regs_pkg;
   // ---------------------------------------------
   // Register map
   // ---------------------------------------------
   localparam logic [7:0]  IDX_EXT_STATUS     = 8'h06;
   localparam logic [7:0]  IDX_NP_TRANSMIT    = 8'h07;
   localparam logic [7:0]  IDX_NP_RECEIVED    = 8'h08;
   localparam logic [7:0]  IDX_NP_CONTROL     = 8'h10;
   localparam int          ADDR_W             = 12;
   localparam logic [11:0] ADDR_EXT_STATUS    = {2'b00, IDX_EXT_STATUS, 2'b00};
   localparam logic [11:0] ADDR_NP_TRANSMIT   = {2'b00, IDX_NP_TRANSMIT, 2'b00};
   localparam logic [11:0] ADDR_NP_RECEIVED   = {2'b00, IDX_NP_RECEIVED, 2'b00};
   localparam logic [11:0] ADDR_NP_CONTROL    = {2'b00, IDX_NP_CONTROL, 2'b00};
   // ---------------------------------------------
   // Fields and reset values
   // ---------------------------------------------
   localparam int          BIT_MORE_PAGES     = 15;
   localparam int          BIT_RSVD_ACK       = 14;
   localparam int          BIT_MESSAGE_PAGE   = 13;
   localparam int          BIT_COMPLY         = 12;
   localparam int          BIT_ALTERNATING    = 11;
   localparam int          CODE_MSB           = 10;
   localparam int          BIT_PAGE_RECEIVED  = 1;
   localparam int          BIT_NP_CAPABLE     = 2;
   localparam logic [15:0] NP_RESET           = 16'h2001;
   localparam logic [15:0] TX_WRITE_MASK      = 16'hb7ff;
   localparam logic [15:0] EXT_CONST          = 16'h0004;
   localparam logic [31:0] NP_CONTROL_RESET   = 32'h0000_0000;
endpackage

// ===== hw/page_bus_if.sv
// Purpose: Carries one link-code word with a strobe
// Assumes: Single clock domain
// Notes:   Used between bank and its helper modules
`timescale 1ns/1ps
`default_nettype none
interface page_bus_if;
   logic        valid;
   logic [15:0] word;
   modport src (output valid, output word);
   modport dst (input  valid, input  word);
endinterface
`default_nettype wire

// ===== hw/np_toggle_gen.sv
// Purpose: Alternating bit tracker for outgoing next pages
// Assumes: Page strobe is one cycle per transmitted page
// Notes:   Seeded from the last base page
`timescale 1ns/1ps
`default_nettype none
module np_toggle_gen
   import np_regs_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_base_sent,
   input  wire logic i_base_alt,
   page_bus_if.dst   sent,
   output logic      o_alternating_bit
);
   import np_regs_pkg::*;

   logic alt_q;
   logic alt_d;

   always_comb begin
      alt_d = alt_q;
      if (i_base_sent) begin
         alt_d = ~i_base_alt; // RULE13
      end else if (sent.valid) begin
         alt_d = ~sent.word[BIT_ALTERNATING]; // RULE13
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         alt_q <= 1'b0;
      end else begin
         alt_q <= alt_d;
      end
   end

   assign o_alternating_bit = alt_q; // RULE7
endmodule
`default_nettype wire

// ===== hw/np_rx_capture.sv
// Purpose: Captures a whole partner page atomically
// Assumes: Strobe marks a complete accepted page
// Notes:   Flags a new page for the status register
`timescale 1ns/1ps
`default_nettype none
module np_rx_capture
   import np_regs_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_rstn,
   page_bus_if.dst   rx,
   output logic [15:0] o_word,
   output logic      o_new_page
);
   logic [15:0] word_q;
   logic [15:0] word_d;
   logic        new_q;
   logic        new_d;

   always_comb begin
      word_d = word_q;
      new_d  = rx.valid;
      if (rx.valid) begin
         word_d = rx.word; // RULE9 RULE14
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         word_q <= NP_RESET;
         new_q  <= 1'b0;
      end else begin
         word_q <= word_d;
         new_q  <= new_d;
      end
   end

   assign o_word     = word_q;
   assign o_new_page = new_q;
endmodule
`default_nettype wire

// ===== verif/link_partner_model.sv
// Purpose: Remote partner sending next pages
// Assumes: One page per send request
// Notes:   Word line changes outside a strobe
`timescale 1ns/1ps
`default_nettype none
module link_partner_model (
   input  wire logic        i_clk,
   input  wire logic        i_send,
   input  wire logic [15:0] i_page,
   output var  logic        o_valid,
   output var  logic [15:0] o_word
);
   initial begin
      o_valid = 1'b0;
      o_word  = 16'h0;
   end
   // Whole page in one strobe; stale word inverted so a late sample shows
   always @(posedge i_clk) begin
      o_valid <= i_send;
      o_word  <= i_send ? i_page : ~o_word;
   end
endmodule
`default_nettype wire

// ===== verif/autoneg_next_page_regs_monitor.sv
// Purpose: Port checks of the next-page bank
// Assumes: Zero-wait APB, tx word lags by one
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs_monitor
   import np_regs_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rstn,
   input wire logic              i_psel,
   input wire logic              i_penable,
   input wire logic              i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0]       i_pwdata,
   input wire logic [3:0]        i_pstrb,
   input wire logic              i_page_sent,
   input wire logic              i_base_sent,
   input wire logic              i_base_alt,
   input wire logic [31:0]       o_prdata,
   input wire logic              o_pready,
   input wire logic              o_pslverr,
   input wire logic [15:0]       o_tx_word
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic setup;
   logic mapped;
   assign setup  = i_psel && !i_penable;
   assign mapped = i_paddr inside {ADDR_EXT_STATUS, ADDR_NP_TRANSMIT, ADDR_NP_RECEIVED, ADDR_NP_CONTROL};
   // ----------------
   // Checks
   // ----------------
   a_answer_next: assert property (setup |=> o_pready && o_pslverr == !$past(mapped))
      else $error("late answer or wrong error");
   a_pready_single: assert property (o_pready |=> !o_pready)
      else $error("pready held");
   a_prdata_quiet: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("read data outside answer");
   a_tx_reserved: assert property (o_tx_word[14] == 1'b0)
      else $error("reserved bit set");
   a_tx_reset_val: assert property (!$past(i_rstn) |-> o_tx_word == NP_RESET)
      else $error("bad reset word");
   a_tx_fields: assert property (setup && i_pwrite && i_paddr == ADDR_NP_TRANSMIT && i_pstrb == 4'hf
      |-> ##2 (o_tx_word & TX_WRITE_MASK) == ($past(i_pwdata[15:0], 2) & TX_WRITE_MASK))
      else $error("tx word not written");
   a_toggle_flip: assert property (i_page_sent && !i_base_sent && !$past(i_page_sent) && !$past(i_base_sent)
      |-> ##2 o_tx_word[11] != $past(o_tx_word[11], 2))
      else $error("toggle did not flip");
   a_toggle_seed: assert property (i_base_sent && !i_page_sent |-> ##2 o_tx_word[11] == !$past(i_base_alt, 2))
      else $error("toggle seed wrong");
   c_unmapped: cover property (setup && !mapped);
   c_page: cover property (i_page_sent);
   c_base: cover property (i_base_sent && i_base_alt);
endmodule
bind autoneg_next_page_regs autoneg_next_page_regs_monitor u_autoneg_next_page_regs_monitor (.i_clk, .i_rstn,
   .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .i_page_sent, .i_base_sent, .i_base_alt,
   .o_prdata, .o_pready, .o_pslverr, .o_tx_word);
`default_nettype wire

// ===== verif/autoneg_next_page_regs_test.sv
// Purpose: Self-checking bench of the bank
// Assumes: Zero-wait APB, 100 MHz clock
// Notes:   Partner model supplies pages
`timescale 1ns/1ps
`default_nettype none
module autoneg_next_page_regs_test;
   import np_regs_pkg::*;
   logic              i_clk, i_rstn, i_psel, i_penable, i_pwrite, i_page_sent, i_base_sent, i_base_alt;
   logic              i_rx_valid, o_pready, o_pslverr, o_np_enable, send, err;
   logic [ADDR_W-1:0] i_paddr;
   logic [31:0]       i_pwdata, o_prdata, rd;
   logic [3:0]        i_pstrb;
   logic [15:0]       i_rx_word, o_tx_word, page;
   int                n_fail, check_count, cyc;
   autoneg_next_page_regs u_autoneg_next_page_regs (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .i_pstrb, .i_page_sent, .i_base_sent, .i_base_alt, .i_rx_valid, .i_rx_word, .o_prdata,
      .o_pready, .o_pslverr, .o_tx_word, .o_np_enable);
   link_partner_model u_link_partner_model (.i_clk, .i_send(send), .i_page(page), .o_valid(i_rx_valid),
      .o_word(i_rx_word));
   always #5 i_clk = ~i_clk;
   // ----------------
   // Tasks
   // ----------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Idle cycle after each transfer keeps one assignment per time step
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      i_pstrb <= s;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(rd, {16'h0, exp});
   endtask
   task automatic pulse(input logic base, input logic alt);
      i_base_sent <= base;
      i_page_sent <= !base;
      i_base_alt <= alt;
      @(posedge i_clk);
      i_base_sent <= 1'b0;
      i_page_sent <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   task automatic do_reset;
      i_rstn <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
   endtask
   task automatic t_reset;
      chk({16'h0, o_tx_word}, {16'h0, NP_RESET});
      chk({31'h0, o_np_enable}, {31'h0, NP_CONTROL_RESET[0]});
      rdc(ADDR_NP_TRANSMIT, NP_RESET);
      rdc(ADDR_NP_RECEIVED, NP_RESET);
      rdc(ADDR_EXT_STATUS, EXT_CONST);
   endtask
   task automatic t_tx_write;
      apb(1'b1, ADDR_NP_TRANSMIT, 32'h0000_bfff, 4'hf);
      rdc(ADDR_NP_TRANSMIT, 16'hb7ff);
      chk({16'h0, o_tx_word}, 32'h0000_b7ff);
      apb(1'b1, ADDR_NP_TRANSMIT, 32'h0000_0800, 4'hf);
      rdc(ADDR_NP_TRANSMIT, 16'h0000);
      apb(1'b1, ADDR_NP_TRANSMIT, 32'h0000_b5a5, 4'h1);
      rdc(ADDR_NP_TRANSMIT, 16'h00a5);
      apb(1'b1, ADDR_NP_TRANSMIT, 32'h0000_3555, 4'h2);
      rdc(ADDR_NP_TRANSMIT, 16'h35a5);
      chk({16'h0, o_tx_word}, 32'h0000_35a5);
   endtask
   task automatic t_toggle;
      pulse(1'b1, 1'b1);
      rdc(ADDR_NP_TRANSMIT, 16'h35a5);
      pulse(1'b0, 1'b0);
      rdc(ADDR_NP_TRANSMIT, 16'h3da5);
      pulse(1'b0, 1'b0);
      rdc(ADDR_NP_TRANSMIT, 16'h35a5);
      pulse(1'b1, 1'b0);
      rdc(ADDR_NP_TRANSMIT, 16'h3da5);
   endtask
   task automatic t_rx(input logic [15:0] w);
      page <= w;
      send <= 1'b1;
      @(posedge i_clk);
      send <= 1'b0;
      repeat (3) @(posedge i_clk);
      rdc(ADDR_NP_RECEIVED, w);
      rdc(ADDR_EXT_STATUS, EXT_CONST | 16'h0002);
      rdc(ADDR_EXT_STATUS, EXT_CONST);
      apb(1'b1, ADDR_NP_RECEIVED, 32'h0, 4'hf);
      chk({31'h0, err}, 32'h0);
      rdc(ADDR_NP_RECEIVED, w);
   endtask
   task automatic t_misc;
      apb(1'b1, 12'h100, 32'h0000_ffff, 4'hf);
      chk({31'h0, err}, 32'h1);
      rdc(12'h100, 16'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, ADDR_NP_CONTROL, 32'h1, 4'hf);
      chk({31'h0, o_np_enable}, 32'h1);
      rdc(ADDR_NP_CONTROL, 16'h0001);
   endtask
   // Page lands on the clearing read's setup edge; the set must win
   task automatic t_flag_race;
      page <= 16'h6abc;
      send <= 1'b1;
      @(posedge i_clk);
      send <= 1'b0;
      @(posedge i_clk);
      rdc(ADDR_EXT_STATUS, EXT_CONST);
      rdc(ADDR_EXT_STATUS, EXT_CONST | 16'h0002);
      rdc(ADDR_EXT_STATUS, EXT_CONST);
      rdc(ADDR_NP_RECEIVED, 16'h6abc);
   endtask
   task automatic close_out;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------
   // Sequence
   // ----------------
   initial begin
      {i_clk, i_rstn, i_psel, i_penable, i_pwrite, i_page_sent, i_base_sent, i_base_alt, send} = '0;
      {i_paddr, i_pwdata, i_pstrb, page} = '0;
      do_reset();
      t_reset();
      t_tx_write();
      t_toggle();
      t_rx(16'hc5a3);
      t_rx(16'h1b3c);
      t_flag_race();
      t_misc();
      do_reset();
      t_reset();
      close_out();
   end
   // Hang guard
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end
endmodule
`default_nettype wire
